// ==== core/och7_ctrl.sv ====
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module och7_ctrl
    import och7_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // nonvolatile store defaults
    input wire logic nv_load_in,
    input wire logic [7:0] nv_ctrl_in,
    input wire logic [7:0] nv_div_in,
    // clock sources, sampled levels
    input wire logic pll1_clk_in,
    input wire logic pll2_clk_in,
    input wire logic pri_ref_in,
    input wire logic sec_ref_in,
    // output driver
    output logic out_p_out,
    output logic out_p_oe_out,
    output logic out_n_out,
    output logic out_n_oe_out,
    output logic [4:0] tail_ma_out,
    output logic [1:0] hcsl_load_out
);

    // every property below runs on the block clock and sleeps through reset
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    och7_ctrl_type ctrl_q;        // channel_seven_output_control
    logic [7:0] div_q;            // channel_seven_output_divider
    logic loaded_q;               // defaults taken from the store
    logic [7:0] rdata_q;          // read data, one cycle after strobe

    wire logic wr_ctrl = reg_wr_in && (reg_addr_in == OCH7_CTRL_ADDR);
    wire logic wr_div = reg_wr_in && (reg_addr_in == OCH7_DIV_ADDR);
    wire logic is_ref = ctrl_q.channel_source_select[1];   // codes 2 and 3
    wire logic div_act = !is_ref && (div_q != 8'h00);

    logic chan_clk_q;             // channel clock before the driver
    wire logic [7:0] stat_word = {5'h00, loaded_q, chan_clk_q, div_act};

    // unmapped reads answer zero
    wire logic [7:0] rd_mux = (reg_addr_in == OCH7_CTRL_ADDR) ? ctrl_q :
                              (reg_addr_in == OCH7_DIV_ADDR) ? div_q :
                              (reg_addr_in == OCH7_STAT_ADDR) ? stat_word : 8'h00;

    // software write wins over a store load in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= OCH7_CTRL_RST;
            div_q <= OCH7_DIV_RST;
            loaded_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= och7_ctrl_type'(reg_wdata_in);
            end else if (nv_load_in) begin
                ctrl_q <= och7_ctrl_type'(nv_ctrl_in);
            end
            if (wr_div) begin
                div_q <= reg_wdata_in;
            end else if (nv_load_in) begin
                div_q <= nv_div_in;
            end
            if (nv_load_in) begin
                loaded_q <= 1'b1;
            end
        end
    end

    // a load with no competing write must land both words
    property p_nv_load;
        (nv_load_in && !reg_wr_in) |=> (div_q == $past(nv_div_in) && ctrl_q == $past(nv_ctrl_in));
    endproperty
    a_nv_load: assert property (p_nv_load) else $error("store defaults not loaded");

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    // ----------------------------------------
    // source select and divider
    // ----------------------------------------
    logic src_lvl_q;              // selected source, sampled
    logic src_prev_q;             // for rising edge detection
    logic [7:0] cnt_q;            // source edges within a divided period

    wire logic src_sel = (ctrl_q.channel_source_select == OCH7_SRC_PLL1) ? pll1_clk_in :
                         (ctrl_q.channel_source_select == OCH7_SRC_PLL2) ? pll2_clk_in :
                         (ctrl_q.channel_source_select == OCH7_SRC_PRI) ? pri_ref_in : sec_ref_in;
    wire logic src_rise = src_lvl_q && !src_prev_q;
    wire logic cnt_wrap = (cnt_q >= div_q);
    // high for the first half of the divided period
    wire logic div_phase = (cnt_q <= {1'b0, div_q[7:1]});

    // sampling stage
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_lvl_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            src_lvl_q <= src_sel;
            src_prev_q <= src_lvl_q;
        end
    end

    // counter restarts whenever the divider value is replaced, by software or
    // by a store load, so it never overshoots the new value
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
        end else if (wr_div || nv_load_in || !div_act) begin
            cnt_q <= 8'h00;
        end else if (src_rise) begin
            cnt_q <= cnt_wrap ? 8'h00 : cnt_q + 8'h01;
        end
    end

    // reference or ratio one: pass the source straight through
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chan_clk_q <= 1'b0;
        end else begin
            chan_clk_q <= div_act ? div_phase : src_lvl_q;
        end
    end

    // source path checks, beside the mux, counter and bypass they guard
    property p_src_pri;
        (ctrl_q.channel_source_select == OCH7_SRC_PRI) |=> (src_lvl_q == $past(pri_ref_in));
    endproperty
    a_src_pri: assert property (p_src_pri) else $error("primary reference not selected");

    property p_ref_bypass;
        is_ref ##1 is_ref |=> (chan_clk_q == $past(src_lvl_q));
    endproperty
    a_ref_bypass: assert property (p_ref_bypass) else $error("reference not bypassed");

    property p_cnt_range;
        cnt_q <= div_q;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("divider count overshoot");

    property p_ref_idle;
        is_ref |=> (cnt_q == 8'h00);
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("divider ran on reference");

    // ----------------------------------------
    // driver decode
    // ----------------------------------------
    wire logic [1:0] fmt = ctrl_q.format_select;
    wire logic [1:0] m1 = ctrl_q.driver_mode_first;
    wire logic [1:0] m2 = ctrl_q.driver_mode_second;
    wire logic is_cmos = (fmt == OCH7_FMT_CMOS);
    wire logic is_diff = (fmt == OCH7_FMT_ACDIFF) || (fmt == OCH7_FMT_HCSL);

    // code 3 gives 16 mA only for hcsl
    wire logic [4:0] ma_d = (m1 == 2'h0) ? OCH7_MA_4 :
                            (m1 == 2'h1) ? OCH7_MA_6 :
                            (m1 == 2'h2) ? OCH7_MA_8 :
                            (fmt == OCH7_FMT_HCSL) ? OCH7_MA_16 : OCH7_MA_8;

    // each leg of a single-ended driver
    wire logic p_oe_cmos = (m1 != OCH7_LEG_TRI);
    wire logic n_oe_cmos = (m2 != OCH7_LEG_TRI);
    wire logic p_lvl_cmos = (m1 == OCH7_LEG_POS) ? chan_clk_q :
                            (m1 == OCH7_LEG_INV) ? !chan_clk_q : 1'b0;
    wire logic n_lvl_cmos = (m2 == OCH7_LEG_POS) ? chan_clk_q :
                            (m2 == OCH7_LEG_INV) ? !chan_clk_q : 1'b0;

    // driver registers; disabled format leaves both legs undriven
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_p_out <= 1'b0;
            out_n_out <= 1'b0;
            out_p_oe_out <= 1'b0;
            out_n_oe_out <= 1'b0;
            tail_ma_out <= 5'h00;
            hcsl_load_out <= 2'h0;
        end else begin
            out_p_oe_out <= is_diff || (is_cmos && p_oe_cmos);
            out_n_oe_out <= is_diff || (is_cmos && n_oe_cmos);
            out_p_out <= is_diff ? chan_clk_q : (is_cmos && p_lvl_cmos);
            out_n_out <= is_diff ? !chan_clk_q : (is_cmos && n_lvl_cmos);
            tail_ma_out <= is_diff ? ma_d : 5'h00;
            hcsl_load_out <= (fmt == OCH7_FMT_HCSL) ? m2 : 2'h0;
        end
    end

    // ----------------------------------------
    // driver assertions
    // ----------------------------------------
    property p_fmt_off;
        (fmt == OCH7_FMT_OFF) |=> (!out_p_oe_out && !out_n_oe_out && tail_ma_out == 5'h00);
    endproperty
    a_fmt_off: assert property (p_fmt_off) else $error("disabled output driven");

    property p_hcsl_16;
        (fmt == OCH7_FMT_HCSL && m1 == 2'h3) |=> (tail_ma_out == 5'h10);
    endproperty
    a_hcsl_16: assert property (p_hcsl_16) else $error("hcsl tail current wrong");

    property p_cmos_low;
        (is_cmos && m1 == OCH7_LEG_LOW) |=> (out_p_oe_out && !out_p_out);
    endproperty
    a_cmos_low: assert property (p_cmos_low) else $error("positive leg not driven low");

    property p_neg_tri;
        (is_cmos && m2 == OCH7_LEG_TRI) |=> !out_n_oe_out;
    endproperty
    a_neg_tri: assert property (p_neg_tri) else $error("negative leg not tristated");

    c_ref_bypass: cover property (is_ref && src_rise);
    c_hcsl_16: cover property (fmt == OCH7_FMT_HCSL && m1 == 2'h3);
    c_cmos_inv: cover property (is_cmos && m1 == OCH7_LEG_INV && m2 == OCH7_LEG_POS);
    c_div_wrap: cover property (div_act && src_rise && cnt_wrap);

endmodule

// ==== core/och7_pkg.sv ====
package och7_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OCH7_CTRL_ADDR = 8'h2b;   // channel_seven_output_control
    localparam logic [7:0] OCH7_DIV_ADDR = 8'h2c;    // channel_seven_output_divider
    localparam logic [7:0] OCH7_STAT_ADDR = 8'h2d;   // read-only live state

    // ----------------------------------------
    // field positions inside the status word
    // ----------------------------------------
    localparam int OCH7_STAT_DIVACT_BIT = 0;   // divider in the clock path
    localparam int OCH7_STAT_CLK_BIT = 1;      // current channel clock level
    localparam int OCH7_STAT_LOADED_BIT = 2;   // nonvolatile defaults loaded

    // ----------------------------------------
    // field encodings
    // ----------------------------------------
    localparam logic [1:0] OCH7_SRC_PLL1 = 2'h0;
    localparam logic [1:0] OCH7_SRC_PLL2 = 2'h1;
    localparam logic [1:0] OCH7_SRC_PRI = 2'h2;
    localparam logic [1:0] OCH7_SRC_SEC = 2'h3;

    localparam logic [1:0] OCH7_FMT_OFF = 2'h0;
    localparam logic [1:0] OCH7_FMT_ACDIFF = 2'h1;
    localparam logic [1:0] OCH7_FMT_HCSL = 2'h2;
    localparam logic [1:0] OCH7_FMT_CMOS = 2'h3;

    // single-ended leg codes, shared by both legs
    localparam logic [1:0] OCH7_LEG_TRI = 2'h0;
    localparam logic [1:0] OCH7_LEG_LOW = 2'h1;
    localparam logic [1:0] OCH7_LEG_INV = 2'h2;
    localparam logic [1:0] OCH7_LEG_POS = 2'h3;

    // tail current in mA
    localparam logic [4:0] OCH7_MA_4 = 5'h04;
    localparam logic [4:0] OCH7_MA_6 = 5'h06;
    localparam logic [4:0] OCH7_MA_8 = 5'h08;
    localparam logic [4:0] OCH7_MA_16 = 5'h10;

    // ----------------------------------------
    // control word layout
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] channel_source_select;   // [7:6]
        logic [1:0] format_select;           // [5:4]
        logic [1:0] driver_mode_first;       // [3:2]
        logic [1:0] driver_mode_second;      // [1:0]
    } och7_ctrl_type;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam och7_ctrl_type OCH7_CTRL_RST = '{OCH7_SRC_PLL1, OCH7_FMT_ACDIFF, 2'h2, 2'h0};
    localparam logic [7:0] OCH7_DIV_RST = 8'h05;

endpackage

// ==== bench/tb_och7_ctrl.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// bench for the channel seven control block
// ----------------------------------------
module tb_och7_ctrl;
    import och7_pkg::*;
    logic mclk_in = 0, rst_n_in = 0;
    logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, nv_ctrl_in = 0, nv_div_in = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, nv_load_in = 0;
    logic [7:0] reg_rdata_out;
    logic out_p_out, out_p_oe_out, out_n_out, out_n_oe_out;
    logic [4:0] tail_ma_out;
    logic [1:0] hcsl_load_out;
    logic [7:0] tick = 8'h00;   // source pattern, each source a different rate
    logic run = 1'b1;           // stops the sources for static driver checks
    logic frz = 1'b0;           // level the stopped sources rest at
    int n_mismatch = 0, compares = 0, p;
    logic [7:0] d, r;
    always #4 mclk_in = ~mclk_in;
    // single driver for the sources, so stopping them cannot race a count
    always @(posedge mclk_in) begin
        tick <= run ? tick + 8'h01 : {8{frz}};
    end
    och7_ctrl uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .nv_load_in(nv_load_in), .nv_ctrl_in(nv_ctrl_in),
        .nv_div_in(nv_div_in), .pll1_clk_in(tick[1]), .pll2_clk_in(tick[2]), .pri_ref_in(tick[3]),
        .sec_ref_in(tick[4]), .out_p_out(out_p_out), .out_p_oe_out(out_p_oe_out),
        .out_n_out(out_n_out), .out_n_oe_out(out_n_oe_out), .tail_ma_out(tail_ma_out),
        .hcsl_load_out(hcsl_load_out));
    // ----------------------------------------
    // shared tasks and expectations
    // ----------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_wdata_in <= v; reg_wr_in <= 1;
        @(posedge mclk_in);
        reg_wr_in <= 0;
    endtask
    // read data is only valid in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_rd_in <= 1;
        @(posedge mclk_in);
        reg_rd_in <= 0;
        #1 v = reg_rdata_out;
    endtask
    // cycles between the second and third rise of the positive leg
    task per(output int c);
        int k, n;
        logic prev;
        n = 0; c = 0; prev = out_p_out;
        for (k = 0; k < 4000 && n < 3; k++) begin
            @(posedge mclk_in);
            #1 c++;
            if (out_p_out === 1'b1 && prev === 1'b0) begin
                n++;
                if (n < 3) c = 0;
            end
            prev = out_p_out;
        end
    endtask
    // {p, p_oe, n, n_oe, tail mA, hcsl load}
    function automatic logic [10:0] exp_drv(input logic [5:0] m, input logic clk);
        logic [1:0] f, a, b;
        f = m[5:4]; a = m[3:2]; b = m[1:0];
        if (f == 2'h0) return 11'h000;
        if (f == 2'h3)
            return {a[1] ? (a[0] ? clk : ~clk) : 1'b0, a != 2'h0,
                    b[1] ? (b[0] ? clk : ~clk) : 1'b0, b != 2'h0, 7'h00};
        return {clk, 1'b1, ~clk, 1'b1,
                a == 2'h0 ? 5'h04 : a == 2'h1 ? 5'h06 : (a == 2'h3 && f == 2'h2) ? 5'h10 : 5'h08,
                f == 2'h2 ? b : 2'h0};
    endfunction
    task final_report;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog: the tests need well under 8000 cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        final_report;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h799c));
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1;
        rd(OCH7_CTRL_ADDR, r); check("ctrl reset", r, 8'h18);
        rd(OCH7_DIV_ADDR, r); check("div reset", r, 8'h05);
        check("tail reset", tail_ma_out, 5'h08);
        rd(8'h00, r); check("unmapped", r, 8'h00);
        // random write then immediate readback
        repeat (8) begin
            d = 8'($urandom);
            p = $urandom % 2;
            wr(p ? OCH7_DIV_ADDR : OCH7_CTRL_ADDR, d);
            rd(p ? OCH7_DIV_ADDR : OCH7_CTRL_ADDR, r); check("readback", r, d);
        end
        // defaults from the nonvolatile store
        d = 8'($urandom);
        @(posedge mclk_in);
        nv_ctrl_in <= d;
        nv_div_in <= ~d;
        nv_load_in <= 1'b1;
        @(posedge mclk_in);
        nv_load_in <= 0;
        rd(OCH7_CTRL_ADDR, r); check("nv ctrl", r, d);
        rd(OCH7_DIV_ADDR, r); check("nv div", r, 8'(~d));
        rd(OCH7_STAT_ADDR, r); check("loaded flag", r[OCH7_STAT_LOADED_BIT], 1'b1);
        // every source through an open divider
        for (int s = 0; s < 4; s++) begin
            wr(OCH7_CTRL_ADDR, {s[1:0], OCH7_FMT_ACDIFF, 4'h8});
            wr(OCH7_DIV_ADDR, 8'h00);
            per(p); check("src period", p, 4 << s);
        end
        // references ignore the divider value
        wr(OCH7_DIV_ADDR, 8'h05);
        wr(OCH7_CTRL_ADDR, {OCH7_SRC_PRI, OCH7_FMT_ACDIFF, 4'h8});
        per(p); check("ref bypass", p, 16);
        wr(OCH7_CTRL_ADDR, {OCH7_SRC_SEC, OCH7_FMT_ACDIFF, 4'h8});
        per(p); check("ref bypass", p, 32);
        // pll divides by n+1, the top value included
        wr(OCH7_CTRL_ADDR, {OCH7_SRC_PLL1, OCH7_FMT_ACDIFF, 4'h8});
        // ratios 2, 3, the top value 256, then a random small one
        for (int i = 0; i < 4; i++) begin
            d = (i == 3) ? 8'h03 + 8'($urandom % 4) : (i == 2 ? 8'hff : 8'(i + 1));
            wr(OCH7_DIV_ADDR, d);
            per(p); check("pll divide", p, 4 * (d + 1));
        end
        // every format and mode pair, sources frozen at both levels
        wr(OCH7_CTRL_ADDR, {OCH7_SRC_PRI, 6'h00});
        for (int l = 0; l < 2; l++) begin
            @(posedge mclk_in);
            run <= 1'b0;
            frz <= l[0];
            for (int m = 0; m < 64; m++) begin
                wr(OCH7_CTRL_ADDR, {OCH7_SRC_PRI, m[5:0]});
                repeat (4) @(posedge mclk_in);
                #1 check("driver", {out_p_out, out_p_oe_out, out_n_out, out_n_oe_out, tail_ma_out,
                    hcsl_load_out}, exp_drv(m[5:0], l[0]));
            end
        end
        final_report;
    end
endmodule
